// ==== sbc_host.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Host side serial master
//------------------------------------------------------------------------------
module sbc_host (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_mosi
);
  // Idle: deselected, clock low
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end
  // Frame of n periods, MSB first, reply collected
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_sck  <= 1'b1;                    // Shift on rising edge
      o_mosi <= w[15-(i%16)];
      repeat (4) @(posedge i_clk);
      r = {r[14:0], i_miso};            // Sample at falling edge
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;                  // Released line must not hold last bit
    repeat (6) @(posedge i_clk);
  endtask : xfer
endmodule : sbc_host

// ==== sbc_pkg.sv ====
//------------------------------------------------------------------------------
// Shared constants for the serial register map
//------------------------------------------------------------------------------
package sbc_pkg;

  // Frame geometry
  localparam int          DATA_W        = 12;      // Functional bits per frame
  localparam int          FRAME_W       = 16;      // Header plus data
  localparam int          CNT_W         = 5;       // Edge counter width
  localparam logic [4:0]  FRAME_BITS    = 5'h10;   // Clock periods per frame
  localparam logic [4:0]  CNT_MAX       = 5'h1F;   // Counter saturation value
  localparam logic [4:0]  FB_LOAD_CNT   = 5'h03;   // Falls seen when select is known
  localparam logic [4:0]  OUT_START_CNT = 5'h04;   // Falls seen before data goes out

  // Header bit positions
  localparam int HDR_ADDR_HI = 15;                 // address_high_bit
  localparam int HDR_ADDR_LO = 14;                 // address_low_bit
  localparam int HDR_FB_SEL  = 13;                 // feedback_select
  localparam int HDR_RO      = 12;                 // readonly_flag

  // Register slots
  localparam logic [1:0] ADDR_MODE  = 2'h0;        // operating_control slot
  localparam logic [1:0] ADDR_EVENT = 2'h1;        // event_unmask slot
  localparam logic [1:0] ADDR_SETUP = 2'h2;        // system_setup / spare_zero slot
  localparam logic [1:0] ADDR_PHY   = 2'h3;        // transceiver_control / spare_one slot

  // Field positions
  localparam int SPARE_ID_BIT    = 11;             // Marks the identification code
  localparam int FBO_DEBUG_BIT   = 0;              // Debug enable in first_boot_options
  localparam int SETUP_DEBUG_BIT = 0;              // software_debug_flag in system_setup
  localparam int PEND_SPI_BIT    = 0;              // SPI failure in pending_event_flags

  // Reset values
  localparam logic [11:0] RST_REG12 = 12'h000;     // Cleared 12-bit register
  localparam logic [4:0]  RST_CNT   = 5'h00;       // Cleared counter

  // Operating modes reported by the system controller
  typedef enum logic [2:0] {
    SBC_MODE_STARTUP_POR,                          // Start-up after power-on
    SBC_MODE_STARTUP,                              // Start-up for any other cause
    SBC_MODE_RESTART,
    SBC_MODE_NORMAL,
    SBC_MODE_STANDBY,
    SBC_MODE_FLASH,
    SBC_MODE_SLEEP,
    SBC_MODE_FAILSAFE
  } sbc_mode_t;

endpackage : sbc_pkg

// ==== sbc_spi_regmap.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Summary of operation
// - A frame is exactly sixteen clock periods.
// - Watchdog period and mode written together.
// - Twelve data bits follow a four-bit header.
// - Every frame shifts out one feedback register.
// - Frame bits fifteen and fourteen give address.
// - Feedback select picks one of two registers.
// - Read-only flag returns data, writes nothing.
// - Writable control bits read back, except the slot zero mode word and first-boot options.
// - First-boot options writable in the first valid frame only; any valid frame locks them.
// - Debug flag readable, clearable in Normal/Standby.
// - Spare zero loads identification code at power-up.
// - Spare one clears at power-up.
// - Only spare zero bit eleven changes itself.
// - Spare bits written only in Start-up/Restart/Flash.
// - Spare registers readable in every mode.
// - Slot one after power-on targets first-boot options.
// - Slot one discards writes in other start modes.
// - Slot zero returns status or diagnosis.
// - Read-only slot zero ignores data, always allowed.
// - Bad frame ignored; failure flag or forced reset.
// - Sample on falling edge, shift on rising edge.
//------------------------------------------------------------------------------
module sbc_spi_regmap #(
  parameter logic [10:0] SPARE_ZERO_ID = 11'h2A5   // Identification code, arbitrary value
) (
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  input  wire logic               i_spi_cs_n,          // Chip select pin, active low
  input  wire logic               i_spi_sck,           // Serial clock pin, idles low
  input  wire logic               i_spi_mosi,          // Serial data from the master
  input  wire sbc_pkg::sbc_mode_t i_sys_mode,          // Current operating mode
  input  wire logic [11:0]        i_health_report,     // System status contents
  input  wire logic [11:0]        i_fault_report,      // System diagnosis contents
  input  wire logic [11:0]        i_event_set,         // Event pulses into pending flags
  output logic                    o_spi_miso,          // Serial data to the master
  output logic                    o_spi_miso_oe,       // High while driving the data pin
  output logic [11:0]             o_operating_control, // Mode and watchdog word
  output logic                    o_mode_write,        // Pulse: new mode word taken
  output logic [11:0]             o_event_unmask,      // Event enables
  output logic [11:0]             o_system_setup,      // Configuration word
  output logic [11:0]             o_transceiver_control, // Physical layer word
  output logic [11:0]             o_first_boot_options,  // One-time options
  output logic                    o_software_debug_flag, // Debug mode active
  output logic [11:0]             o_pending_event_flags, // Pending events
  output logic                    o_frame_error,       // Pulse: wrong clock count
  output logic                    o_force_reset        // Pulse: reset request
);
  import sbc_pkg::*;

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] shift_in;          // Received frame, MSB first
    logic [4:0]  bit_cnt;           // Falling edges in this frame
    logic [11:0] shift_out;         // Feedback word being sent
    logic        miso;              // Data pin value
    logic        miso_oe;           // Data pin enable
    logic        sck_prev;          // Clock level one cycle back
    logic        cs_prev;           // Select level one cycle back
    logic [11:0] pend_read;         // Pending bits returned this frame
    logic [11:0] operating_control;
    logic        mode_write;
    logic [11:0] event_unmask;
    logic [11:0] system_setup;
    logic [11:0] transceiver_control;
    logic [11:0] first_boot_options;
    logic        boot_lock;         // First-boot options closed
    logic        sw_debug;          // software_debug_flag
    logic [11:0] spare_zero;
    logic [11:0] spare_one;
    logic [11:0] pending;           // pending_event_flags
    logic        frame_error;
    logic        force_reset;
  } sbc_state_t;

  localparam sbc_state_t S_RESET = '{
    shift_in:            16'h0000,
    bit_cnt:             RST_CNT,
    shift_out:           RST_REG12,
    miso:                1'b0,
    miso_oe:             1'b0,
    sck_prev:            1'b0,
    cs_prev:             1'b1,
    pend_read:           RST_REG12,
    operating_control:   RST_REG12,
    mode_write:          1'b0,
    event_unmask:        RST_REG12,
    system_setup:        RST_REG12,
    transceiver_control: RST_REG12,
    first_boot_options:  RST_REG12,
    boot_lock:           1'b0,
    sw_debug:            1'b0,
    spare_zero:          {1'b1, SPARE_ZERO_ID},
    spare_one:           RST_REG12,
    pending:             RST_REG12,
    frame_error:         1'b0,
    force_reset:         1'b0
  };

  sbc_state_t  s_q;                 // Registered state
  sbc_state_t  s_d;                 // Next state

  //----------------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------------
  logic        cs_n_s;              // Synchronised chip select
  logic [1:0]  sck_mosi_s;          // Synchronised clock and data

  sbc_sync #(.WIDTH(1), .RST_VAL(16'h0001)) u_sync_cs (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_spi_cs_n),
    .o_sync    (cs_n_s)
  );

  sbc_sync #(.WIDTH(2), .RST_VAL(16'h0000)) u_sync_sck (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_spi_sck, i_spi_mosi}),
    .o_sync    (sck_mosi_s)
  );

  //----------------------------------------------------------------------------
  // Decode helpers
  //----------------------------------------------------------------------------
  logic        sck_s;               // Clock after sync
  logic        mosi_s;              // Data after sync
  logic        cs_fall;             // Frame opens
  logic        cs_rise;             // Frame closes
  logic        sck_fall;            // Sample point
  logic        sck_rise;            // Shift point
  logic        in_frame;            // Select held low
  logic [15:0] shift_nxt;           // Frame after taking one more bit
  logic [1:0]  fb_addr;             // Address known at feedback load
  logic        fb_sel;              // Feedback select known at feedback load
  logic        load_fb;             // Feedback register captured this cycle
  logic [11:0] feedback;            // Selected feedback word
  logic        frame_ok;            // Closing frame had the right length
  logic [1:0]  w_addr;              // Address of the closing frame
  logic        w_ro;                // Read-only flag of the closing frame
  logic [11:0] w_data;              // Data of the closing frame
  logic        run_mode;            // Normal or Standby
  logic        spare_mode;          // Start-up, Restart or Flash
  logic        start_mode;          // Start-up or Restart
  logic [11:0] setup_readback;      // Setup word with live debug flag

  assign sck_s    = sck_mosi_s[1];
  assign mosi_s   = sck_mosi_s[0];
  assign in_frame = !cs_n_s;
  assign cs_fall  = s_q.cs_prev && !cs_n_s;
  assign cs_rise  = !s_q.cs_prev && cs_n_s;
  assign sck_fall = in_frame && s_q.sck_prev && !sck_s;
  assign sck_rise = in_frame && !s_q.sck_prev && sck_s;
  assign shift_nxt = {s_q.shift_in[14:0], mosi_s};
  assign fb_addr  = shift_nxt[2:1];
  assign fb_sel   = shift_nxt[0];
  assign load_fb  = sck_fall && (s_q.bit_cnt == (FB_LOAD_CNT - 5'h01));
  assign frame_ok = (s_q.bit_cnt == FRAME_BITS);
  assign w_addr   = s_q.shift_in[HDR_ADDR_HI:HDR_ADDR_LO];
  assign w_ro     = s_q.shift_in[HDR_RO];
  assign w_data   = s_q.shift_in[DATA_W-1:0];
  assign run_mode   = (i_sys_mode == SBC_MODE_NORMAL) || (i_sys_mode == SBC_MODE_STANDBY);
  assign start_mode = (i_sys_mode == SBC_MODE_STARTUP_POR) || (i_sys_mode == SBC_MODE_STARTUP)
                   || (i_sys_mode == SBC_MODE_RESTART);
  assign spare_mode = start_mode || (i_sys_mode == SBC_MODE_FLASH);

  // Debug flag shown live inside the setup readback
  always_comb begin
    setup_readback                  = s_q.system_setup;
    setup_readback[SETUP_DEBUG_BIT] = s_q.sw_debug;
  end

  // Feedback word chosen by address and select
  always_comb begin
    unique case (fb_addr)
      ADDR_MODE:  feedback = fb_sel ? i_fault_report : i_health_report;
      ADDR_EVENT: feedback = fb_sel ? s_q.pending    : s_q.event_unmask;
      ADDR_SETUP: feedback = fb_sel ? s_q.spare_zero : setup_readback;
      ADDR_PHY:   feedback = fb_sel ? s_q.spare_one  : s_q.transceiver_control;
    endcase
  end

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    s_d             = s_q;
    s_d.sck_prev    = sck_s;
    s_d.cs_prev     = cs_n_s;
    s_d.mode_write  = 1'b0;
    s_d.frame_error = 1'b0;
    s_d.force_reset = 1'b0;
    // Frame opens: clear receiver, take the data pin
    if (cs_fall) begin
      s_d.shift_in  = 16'h0000;
      s_d.bit_cnt   = RST_CNT;
      s_d.miso      = 1'b0;
      s_d.miso_oe   = 1'b1;
      s_d.pend_read = RST_REG12;
    end
    // Sample on the falling edge, saturating the count
    if (sck_fall) begin
      s_d.shift_in = shift_nxt;
      if (s_q.bit_cnt != CNT_MAX) begin
        s_d.bit_cnt = s_q.bit_cnt + 5'h01;
      end
    end
    // Address and select known: capture the feedback word for this frame
    if (load_fb) begin
      s_d.shift_out = feedback;
      if ((fb_addr == ADDR_EVENT) && fb_sel) begin
        s_d.pend_read = s_q.pending;
      end
    end
    // Shift on the rising edge; header periods send zero
    if (sck_rise) begin
      if ((s_q.bit_cnt >= OUT_START_CNT) && (s_q.bit_cnt < FRAME_BITS)) begin
        s_d.miso      = s_q.shift_out[DATA_W-1];
        s_d.shift_out = {s_q.shift_out[DATA_W-2:0], 1'b0};
      end else begin
        s_d.miso = 1'b0;
      end
    end
    // Frame closes: commit or reject
    if (cs_rise) begin
      s_d.miso    = 1'b0;
      s_d.miso_oe = 1'b0;
      if (frame_ok) begin
        s_d.boot_lock = 1'b1;
        s_d.pending   = s_q.pending & ~s_q.pend_read;
        if (!w_ro) begin
          unique case (w_addr)
            ADDR_MODE: begin
              s_d.operating_control = w_data;
              s_d.mode_write        = 1'b1;
            end
            ADDR_EVENT: begin
              if (run_mode) begin
                s_d.event_unmask = w_data;
              end else if ((i_sys_mode == SBC_MODE_STARTUP_POR) && !s_q.boot_lock) begin
                s_d.first_boot_options = w_data;
                s_d.sw_debug           = w_data[FBO_DEBUG_BIT];
              end
              // Other modes discard the data
            end
            ADDR_SETUP: begin
              if (run_mode) begin
                s_d.system_setup = w_data;
                if (!w_data[SETUP_DEBUG_BIT]) begin
                  s_d.sw_debug = 1'b0;
                end
              end else if (spare_mode) begin
                s_d.spare_zero = {1'b0, w_data[SPARE_ID_BIT-1:0]};
              end
            end
            ADDR_PHY: begin
              if (run_mode) begin
                s_d.transceiver_control = w_data;
              end else if (spare_mode) begin
                s_d.spare_one = w_data;
              end
            end
          endcase
        end
      end else begin
        // Wrong length: nothing stored
        s_d.frame_error = 1'b1;
        if (start_mode) begin
          s_d.force_reset = 1'b1;
        end else if (s_q.event_unmask[PEND_SPI_BIT]) begin
          s_d.pending[PEND_SPI_BIT] = 1'b1;
        end
      end
    end
    // Events set last so they win over a read clear
    s_d.pending = s_d.pending | i_event_set;
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= S_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign o_spi_miso            = s_q.miso;
  assign o_spi_miso_oe         = s_q.miso_oe;
  assign o_operating_control   = s_q.operating_control;
  assign o_mode_write          = s_q.mode_write;
  assign o_event_unmask        = s_q.event_unmask;
  assign o_system_setup        = s_q.system_setup;
  assign o_transceiver_control = s_q.transceiver_control;
  assign o_first_boot_options  = s_q.first_boot_options;
  assign o_software_debug_flag = s_q.sw_debug;
  assign o_pending_event_flags = s_q.pending;
  assign o_frame_error         = s_q.frame_error;
  assign o_force_reset         = s_q.force_reset;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Wrong-length frames never store the mode word and always flag
  a_bad_frame_drop: assert property (
    (cs_rise && !frame_ok) |=> (s_q.frame_error && !s_q.mode_write
                               && $stable(s_q.operating_control)))
    else $error("bad frame was not rejected");
  // Mode word carries the whole data field in one write
  a_mode_word_whole: assert property (
    (cs_rise && frame_ok && !w_ro && (w_addr == ADDR_MODE))
      |=> (s_q.mode_write && (s_q.operating_control == $past(w_data))))
    else $error("mode word not taken as a whole");
  // Read-only frames leave the mode, setup, event unmask and spare one registers alone
  a_readonly_hold: assert property (
    (cs_rise && frame_ok && w_ro) |=> ($stable(s_q.operating_control) && !s_q.mode_write
      && $stable(s_q.system_setup) && $stable(s_q.spare_one) && $stable(s_q.event_unmask)))
    else $error("read-only frame changed a register");
  // Status word is captured for slot zero with select low
  a_status_feedback: assert property (
    (load_fb && (fb_addr == ADDR_MODE) && !fb_sel)
      |=> (s_q.shift_out == $past(i_health_report)))
    else $error("status word not loaded for feedback");
  // Lock is permanent and freezes the options
  a_boot_lock_hold: assert property (
    s_q.boot_lock |=> (s_q.boot_lock && $stable(s_q.first_boot_options)))
    else $error("first-boot options changed after lock");
  // Spare bits only move in spare-capable modes
  a_spare_guard: assert property (
    !spare_mode |=> ($stable(s_q.spare_one) && $stable(s_q.spare_zero)))
    else $error("spare register changed in wrong mode");
  // Identification marker can only fall
  a_spare_id_mark: assert property (
    !$rose(s_q.spare_zero[SPARE_ID_BIT]))
    else $error("identification marker set again");
  // Start modes turn a bad frame into a reset request
  a_bad_frame_reset: assert property (
    (cs_rise && !frame_ok && start_mode) |=> (s_q.force_reset ##1 !s_q.force_reset))
    else $error("bad frame in start mode gave no reset pulse");
  // Setting an event wins over a clear in the same cycle
  a_event_set_wins: assert property (
    (i_event_set != RST_REG12) |=> ((s_q.pending & $past(i_event_set)) == $past(i_event_set)))
    else $error("event lost against a clear");
  // Data pin is quiet outside frames
  a_miso_idle: assert property (
    !s_q.miso_oe |-> !s_q.miso)
    else $error("data pin high while released");
  c_mode_write:  cover property (cs_rise && frame_ok && !w_ro && (w_addr == ADDR_MODE));
  c_readonly:    cover property (cs_rise && frame_ok && w_ro);
  c_bad_frame:   cover property (cs_rise && !frame_ok);
  c_spare_write: cover property ($fell(s_q.spare_zero[SPARE_ID_BIT]));

endmodule : sbc_spi_regmap

// ==== sbc_sync.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
//------------------------------------------------------------------------------
module sbc_sync #(
  parameter int          WIDTH    = 1,             // Number of bits
  parameter logic [15:0] RST_VAL  = 16'h0000       // Idle level of each bit
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;                        // First stage, read only below

  // Two flops in series; only the second stage is visible
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= RST_VAL[WIDTH-1:0];
      o_sync <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : sbc_sync

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import sbc_pkg::*;
  localparam logic [10:0] ID = 11'h2A5;   // Arbitrary identification value
  logic        i_clk, i_reset_n, cs_n, sck, mosi, miso;
  sbc_mode_t   mode;
  logic [11:0] opc, unm, setup, phy, fbo, pend;
  logic        mw, dbg, fe, fr_p, oe;
  logic [11:0] evt;                       // Event pulses into the pending flags
  logic [15:0] r;
  int          err_total, checks_done, n_mw, n_fe, n_fr, n_oe;
  sbc_spi_regmap #(.SPARE_ZERO_ID(ID)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_cs_n(cs_n), .i_spi_sck(sck),
    .i_spi_mosi(mosi), .i_sys_mode(mode), .i_health_report(12'hA5C),
    .i_fault_report(12'h3C1), .i_event_set(evt), .o_spi_miso(miso),
    .o_spi_miso_oe(oe), .o_operating_control(opc), .o_mode_write(mw),
    .o_event_unmask(unm), .o_system_setup(setup), .o_transceiver_control(phy),
    .o_first_boot_options(fbo), .o_software_debug_flag(dbg),
    .o_pending_event_flags(pend), .o_frame_error(fe), .o_force_reset(fr_p));
  sbc_host u_host (.i_clk(i_clk), .i_miso(miso), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Pulse counters
  always @(posedge i_clk) begin
    if (mw === 1'b1) n_mw++;
    if (fe === 1'b1) n_fe++;
    if (fr_p === 1'b1) n_fr++;
    if (oe === 1'b1) n_oe++;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // One frame; the data pin must be driven exactly while select is low
  task automatic fr(logic [1:0] a, logic s, logic o, logic [11:0] d, int n = 16);
    n_oe = 0;
    u_host.xfer({a, s, o, d}, n, r);
    chk(n_oe[15:0], 16'(4 + 8 * n));
  endtask : fr
  // Reset, also used mid-run to reopen the one-time options
  task automatic do_reset;
    i_reset_n <= 1'b0;
    mode      <= SBC_MODE_STARTUP_POR;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : do_reset
  task automatic t_discard;
    mode <= SBC_MODE_STARTUP;
    fr(2'h1, 1'b0, 1'b0, 12'hFFF);
    chk({fbo, 3'h0, dbg}, 16'h0000);
    chk({4'h0, unm}, 16'h0000);
  endtask : t_discard
  task automatic t_boot;
    fr(2'h1, 1'b0, 1'b0, 12'h001);
    chk({fbo, 3'h0, dbg}, 16'h0011);
    fr(2'h1, 1'b0, 1'b0, 12'h000);
    chk({4'h0, fbo}, 16'h0001);
    fr(2'h2, 1'b1, 1'b1, 12'h000);
    chk(r, {5'h01, ID});
    fr(2'h3, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0000);
  endtask : t_boot
  task automatic t_spare;
    mode <= SBC_MODE_STARTUP;
    fr(2'h2, 1'b0, 1'b0, 12'h123);
    fr(2'h1, 1'b0, 1'b0, 12'h000);
    chk({4'h0, fbo}, 16'h0001);
    fr(2'h2, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0123);
    fr(2'h3, 1'b0, 1'b0, 12'hABC);
    fr(2'h3, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0ABC);
    mode <= SBC_MODE_FLASH;
    fr(2'h3, 1'b0, 1'b0, 12'h456);
    fr(2'h3, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0456);
    chk({4'h0, setup | phy}, 16'h0000);
  endtask : t_spare
  task automatic t_normal;
    mode <= SBC_MODE_NORMAL;
    fr(2'h2, 1'b0, 1'b0, 12'h5A0);
    chk({setup, 3'h0, dbg}, 16'h5A00);
    fr(2'h2, 1'b0, 1'b1, 12'h000);
    chk(r, 16'h05A0);
    mode <= SBC_MODE_STANDBY;
    fr(2'h3, 1'b0, 1'b0, 12'h3C3);
    fr(2'h3, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0456);
    chk({4'h0, phy}, 16'h03C3);
    fr(2'h1, 1'b0, 1'b0, 12'h001);
    fr(2'h1, 1'b0, 1'b1, 12'h000);
    chk(r, 16'h0001);
    chk({4'h0, unm}, 16'h0001);
    mode <= SBC_MODE_SLEEP;
    fr(2'h3, 1'b0, 1'b0, 12'hFFF);
    mode <= SBC_MODE_FAILSAFE;
    fr(2'h3, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0456);
    chk({4'h0, phy}, 16'h03C3);
  endtask : t_normal
  task automatic t_mode;
    fr(2'h0, 1'b0, 1'b1, 12'hFFF);
    chk(r, 16'h0A5C);
    chk({opc, n_mw[3:0]}, 16'h0000);
    fr(2'h0, 1'b1, 1'b0, 12'h6C9);
    chk(r, 16'h03C1);
    chk({opc, n_mw[3:0]}, 16'h6C91);
  endtask : t_mode
  task automatic t_bad;
    fr(2'h0, 1'b0, 1'b0, 12'h777, 15);
    chk({opc, n_fe[3:0]}, 16'h6C91);
    evt <= 12'h100;
    @(posedge i_clk);
    evt <= 12'h000;
    fr(2'h1, 1'b1, 1'b1, 12'h000);
    chk(r, 16'h0101);
    chk({4'h0, pend}, 16'h0000);
    mode <= SBC_MODE_RESTART;
    fr(2'h2, 1'b0, 1'b0, 12'h777, 17);
    chk({8'h00, n_fr[3:0], n_fe[3:0]}, 16'h0012);
  endtask : t_bad
  // Main sequence
  initial begin
    {err_total, checks_done, n_mw, n_fe, n_fr, n_oe} = '0;
    evt       = 12'h000;
    i_reset_n = 1'b0;
    do_reset();
    t_discard();
    do_reset();
    t_boot();
    t_spare();
    t_normal();
    t_mode();
    t_bad();
    end_sim();
  end
  // Watchdog, run needs about 0.17 ms
  initial begin
    #1ms;
    err_total++;
    end_sim();
  end
endmodule : tb_top
